// ===== hw/ifbx_ctrl.sv
// Operation
// (RULE_01) File subcycle only from idle on file load/store; multiple versus single.
// (RULE_02) Multiple load: invalidate last destination, request load, preset request counter five.
// (RULE_03) Read accept sets increment flag; alpha grows by eight next clock.
// (RULE_04) Multiple load decrements nonzero completion counter per request; six requests total.
// (RULE_05) Single register-file transfer waits on alpha and result octet hazards.
// (RULE_06) Then file-to-file, invalidate, clear flags, acknowledge pass, return idle.
// (RULE_07) Store zeroes in register file needs write accept.
// (RULE_08) Memory single file loops on alpha memory hazard until forced write empties buffer.
// (RULE_09) Hazards clear: both counters loaded with zero, one octet.
// (RULE_10) Single memory load: invalidate, request, on accept wait then request state.
// (RULE_11) Stall single store on pending buffer octet matching alpha.
// (RULE_12) Then store request and clear matching buffer activity bit.
// (RULE_13) Loop until write accept, then clear flags and acknowledge pass.
// (RULE_14) Exchange and two counting branches enter branch/exchange subcycle from idle.
// (RULE_15) Branch first pass waits on result and test register hazards.
// (RULE_16) Then register-to-pipe, level 3 to 4 transfer, set hold.
// (RULE_17) Count in count operand; index upper, compare lower of pair operand.
// (RULE_18) Count plus upper plus inverted lower; carry out decides branch.
// (RULE_19) Second pass sets branch done only and returns idle; the code also latches branchTaken from the carry in this pass.
// (RULE_20) Third pass exits to decide subcycle.
// (RULE_21) Exchange takes two passes; register write/read hazard ignored.
// (RULE_22) Exchange first pass waits on result register hazard.
// (RULE_23) Alpha in register file when not inhibited, alpha at most 2F, modifier zero.
// (RULE_24) Register-to-pipe at once if no hazard or alpha zero non-doubleword.
// (RULE_25) Recoverable hazard: set short circuit flag and start register-to-pipe.
// (RULE_26) Alpha outside register file: memory-to-pipe; always transfer and set hold.
// (RULE_27) Exchange second pass: register data down pipe, clear flags, acknowledge pass.
// (RULE_28) Each hazard wait returns idle with flags unchanged, re-deciding next clock.
//
// Decided for this implementation: the address map and register access over Avalon-MM.
`default_nettype none

module ifbx_ctrl (
  input wire logic clk, // 250 MHz control clock
  input wire logic rst_n, // async reset, active low
  input wire logic [ifbx_pkg::BUS_AW-1:0] avs_address, // byte address
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire ifbx_pkg::ifbx_instr_s instr, // level 3 instruction
  input wire ifbx_pkg::ifbx_haz_s haz, // pipeline hazards
  input wire ifbx_pkg::ifbx_buf_s bufs, // buffer address registers
  input wire logic readAccept, // requester takes a read
  input wire logic writeAccept, // requester takes a write
  output ifbx_pkg::ifbx_out_s ctl, // control pulses
  output logic [ifbx_pkg::ALPHA_W-1:0] alphaAddr, // alpha address register
  output logic [31:0] level4CountOperand, // branch count
  output logic [63:0] level4PairOperand, // index and compare
  output logic branchTaken // adder carry
);
  import ifbx_pkg::*;

  // ************************************************************
  // State
  // ************************************************************
  ifbx_state_s s_ff;
  ifbx_state_s nxt_s;
  logic isRegFile;
  logic isBranch;
  logic xMatch;
  logic yMatch;
  logic storeHaz;
  logic busReq;
  logic [33:0] testSum;

  // ************************************************************
  // Decode and branch adder
  // ************************************************************
  // (RULE_23) register file test
  assign isRegFile = !instr.regInhibit && (instr.alpha <= REGFILE_TOP) &&
                     (instr.modifier == MOD_ZERO);
  assign isBranch = (instr.kind == IFBX_K_BR_LE) || (instr.kind == IFBX_K_BR_GT);
  assign xMatch = bufs.xActive && (bufs.xAddr == instr.alpha);
  assign yMatch = bufs.yActive && (bufs.yAddr == instr.alpha);
  // (RULE_11) pending octet hazard
  assign storeHaz = (xMatch && !bufs.xFull) || (yMatch && !bufs.yFull);
  // (RULE_18) carry decides branch
  assign testSum = {2'b00, s_ff.cntOp} + {2'b00, s_ff.pairOp[63:32]} +
                   {2'b00, ~s_ff.pairOp[31:0]};
  assign busReq = avs_read || avs_write;
  assign avs_waitrequest = busReq && !s_ff.busAck;
  assign avs_readdata = s_ff.rdData;
  assign alphaAddr = s_ff.alpha;
  assign level4CountOperand = s_ff.cntOp;
  assign level4PairOperand = s_ff.pairOp;
  assign branchTaken = s_ff.branchTaken;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    nxt_s = s_ff;
    ctl = '0;
    nxt_s.alphaInc = 1'b0;
    // Register bus: read data captured in the first cycle, write data taken and answered in the second.
    nxt_s.busAck = busReq && !s_ff.busAck;
    if (busReq && !s_ff.busAck && avs_read) begin
      nxt_s.rdData = '0;
      unique case (avs_address)
        REG_CTRL: nxt_s.rdData[CTRL_EN_BIT] = s_ff.enable;
        REG_STATUS: begin
          nxt_s.rdData[STAT_FSM_LSB +: 2] = s_ff.fsm;
          nxt_s.rdData[STAT_HOLD_BIT] = s_ff.hold;
          nxt_s.rdData[STAT_BDONE_BIT] = s_ff.branchDone;
          nxt_s.rdData[STAT_TAKEN_BIT] = s_ff.branchTaken;
          nxt_s.rdData[STAT_REQ_LSB +: 3] = s_ff.reqCnt;
          nxt_s.rdData[STAT_CMP_LSB +: 3] = s_ff.cmpCnt;
        end
        REG_ALPHA: nxt_s.rdData[ALPHA_W-1:0] = s_ff.alpha;
        default: nxt_s.rdData = '0;
      endcase
    end
    if (s_ff.busAck && avs_write && avs_address == REG_CTRL && avs_byteenable[0]) begin
      nxt_s.enable = avs_writedata[CTRL_EN_BIT];
    end
    // (RULE_03) advance alpha one octet
    if (s_ff.alphaInc) begin
      nxt_s.alpha = s_ff.alpha + ALPHA_STEP;
    end else if (s_ff.fsm == IFBX_IDLE) begin
      nxt_s.alpha = instr.alpha;
    end
    // (RULE_28) waits fall through idle unchanged
    unique case (s_ff.fsm)
      IFBX_IDLE: begin
        if (s_ff.enable) begin
          unique case (instr.kind)
            // (RULE_01) multiple file kinds
            IFBX_K_LOAD_MULT, IFBX_K_STORE_MULT: begin
              if (haz.pipeBusy || haz.forcedWriteBusy) begin
                ctl = '0;
              end else if (haz.zFull) begin
                ctl.forcedWrite = 1'b1;
              end else begin
                // (RULE_02) preset and request
                nxt_s.reqCnt = MULT_PRESET;
                nxt_s.cmpCnt = MULT_PRESET;
                nxt_s.storeOp = (instr.kind == IFBX_K_STORE_MULT);
                if (instr.kind == IFBX_K_LOAD_MULT) begin
                  ctl.ldInvalidate = 1'b1;
                  ctl.fileLoadReq = 1'b1;
                  nxt_s.alphaInc = readAccept;
                  nxt_s.fsm = readAccept ? IFBX_OWAIT : IFBX_IDLE;
                end else begin
                  ctl.fileStoreReq = 1'b1;
                  ctl.clearXActive = xMatch;
                  ctl.clearYActive = yMatch;
                  nxt_s.alphaInc = writeAccept;
                  nxt_s.fsm = writeAccept ? IFBX_OWAIT : IFBX_IDLE;
                end
              end
            end
            IFBX_K_LOAD_SINGLE, IFBX_K_STORE_SINGLE, IFBX_K_STORE_ZERO: begin
              if (isRegFile) begin
                // (RULE_05) octet hazards hold off
                // (RULE_07) zero fill needs empty bus
                if (!haz.alphaRegHaz && !haz.resultOctetHaz &&
                    (instr.kind != IFBX_K_STORE_ZERO || writeAccept)) begin
                  // (RULE_06) file to file done
                  ctl.fileToFile = 1'b1;
                  ctl.storeZero = (instr.kind == IFBX_K_STORE_ZERO);
                  ctl.ldInvalidate = 1'b1;
                  ctl.clearExecInhibit = 1'b1;
                  ctl.passAck = 1'b1;
                end
              end else if (haz.alphaMemHaz) begin
                // (RULE_08) drain the write buffer
                ctl.forcedWrite = haz.zFull && !haz.forcedWriteBusy;
              end else if (!haz.resultMemHaz) begin
                // (RULE_09) one octet only
                nxt_s.reqCnt = SINGLE_PRESET;
                nxt_s.cmpCnt = SINGLE_PRESET;
                if (instr.kind == IFBX_K_LOAD_SINGLE) begin
                  // (RULE_10) single load request
                  ctl.ldInvalidate = 1'b1;
                  ctl.fileLoadReq = 1'b1;
                  nxt_s.storeOp = 1'b0;
                  nxt_s.alphaInc = readAccept;
                  nxt_s.fsm = readAccept ? IFBX_OWAIT : IFBX_IDLE;
                end else if (!storeHaz) begin
                  // (RULE_12) store and drop buffer match
                  ctl.fileStoreReq = 1'b1;
                  ctl.clearXActive = xMatch;
                  ctl.clearYActive = yMatch;
                  // (RULE_13) finish on write accept
                  if (writeAccept) begin
                    ctl.clearExecInhibit = 1'b1;
                    ctl.passAck = 1'b1;
                  end
                end
              end
            end
            // (RULE_14) branch and exchange subcycle
            IFBX_K_BR_LE, IFBX_K_BR_GT: begin
              if (!s_ff.hold) begin
                // (RULE_15) result and test hazards
                if (!haz.resultRegHaz && !haz.testRegHaz) begin
                  // (RULE_16) operands to level 4
                  ctl.seqRegToPipe = 1'b1;
                  ctl.l3ToL4 = 1'b1;
                  nxt_s.hold = 1'b1;
                  // (RULE_17) operand arrangement
                  nxt_s.cntOp = instr.testCount;
                  nxt_s.pairOp = {instr.testIndex, instr.testCompare};
                end
              end else if (!s_ff.branchDone) begin
                // (RULE_19) settle pass
                nxt_s.branchDone = 1'b1;
                nxt_s.branchTaken = |testSum[33:32];
              end else begin
                // (RULE_20) hand to decide
                ctl.decideGo = 1'b1;
                nxt_s.hold = 1'b0;
                nxt_s.branchDone = 1'b0;
              end
            end
            IFBX_K_EXCHANGE: begin
              if (!s_ff.hold) begin
                // (RULE_22) result register hazard
                if (!haz.resultRegHaz) begin
                  if (!isRegFile) begin
                    // (RULE_26) memory source
                    ctl.seqMemToPipe = 1'b1;
                  end else if (!haz.alphaRegHaz ||
                               (instr.alpha == ALPHA_ZERO && !instr.doubleword)) begin
                    // (RULE_24) no hazard or fixed zero
                    ctl.seqRegToPipe = 1'b1;
                  end else if (haz.shortCircuitOk) begin
                    // (RULE_25) short circuit recovery
                    ctl.shortCircuitL4 = 1'b1;
                    ctl.seqRegToPipe = 1'b1;
                  end
                  // (RULE_26) transfer and hold
                  ctl.l3ToL4 = ctl.seqRegToPipe || ctl.seqMemToPipe;
                  nxt_s.hold = ctl.l3ToL4;
                end
              end else begin
                // (RULE_21) no hazard check on second pass
                // (RULE_27) register data toward alpha
                ctl.seqRegToPipe = 1'b1;
                ctl.l3ToL4 = 1'b1;
                ctl.clearExecInhibit = 1'b1;
                ctl.passAck = 1'b1;
                nxt_s.hold = 1'b0;
              end
            end
            default: ctl = '0;
          endcase
        end
      end
      IFBX_OWAIT: nxt_s.fsm = IFBX_OREQ;
      IFBX_OREQ: begin
        // (RULE_04) request until completion count spent
        if (s_ff.cmpCnt == SINGLE_PRESET) begin
          ctl.clearExecInhibit = 1'b1;
          ctl.passAck = 1'b1;
          nxt_s.fsm = IFBX_IDLE;
        end else begin
          ctl.fileLoadReq = !s_ff.storeOp;
          ctl.fileStoreReq = s_ff.storeOp;
          if (s_ff.storeOp ? writeAccept : readAccept) begin
            nxt_s.alphaInc = 1'b1;
            nxt_s.cmpCnt = s_ff.cmpCnt - CNT_STEP;
            nxt_s.reqCnt = (s_ff.reqCnt == SINGLE_PRESET) ? s_ff.reqCnt :
                           s_ff.reqCnt - CNT_STEP;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
      s_ff.enable <= CTRL_EN_RESET;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  property p_mult_preset;
    @(posedge clk) disable iff (!rst_n)
    (ctl.fileLoadReq && s_ff.fsm == IFBX_IDLE && instr.kind == IFBX_K_LOAD_MULT)
      |=> (s_ff.cmpCnt == 3'h5) && (s_ff.reqCnt == 3'h5);
  endproperty
  a_mult_preset: assert property (p_mult_preset) else $error("multiple preset wrong"); // RULE_02

  property p_alpha_step;
    @(posedge clk) disable iff (!rst_n)
    (ctl.fileLoadReq && readAccept) |=> s_ff.alphaInc ##1 (s_ff.alpha == $past(s_ff.alpha) + 24'h000008);
  endproperty
  a_alpha_step: assert property (p_alpha_step) else $error("alpha not advanced"); // RULE_03

  property p_req_end;
    @(posedge clk) disable iff (!rst_n)
    (s_ff.fsm == IFBX_OREQ && s_ff.cmpCnt == 3'h0) |-> ctl.passAck && !ctl.fileLoadReq;
  endproperty
  a_req_end: assert property (p_req_end) else $error("request phase did not end"); // RULE_04

  property p_octet_haz;
    @(posedge clk) disable iff (!rst_n)
    (haz.alphaRegHaz || haz.resultOctetHaz) |-> !ctl.fileToFile;
  endproperty
  a_octet_haz: assert property (p_octet_haz) else $error("transfer under hazard"); // RULE_05

  property p_single_cnt;
    @(posedge clk) disable iff (!rst_n)
    (ctl.fileLoadReq && s_ff.fsm == IFBX_IDLE && instr.kind == IFBX_K_LOAD_SINGLE)
      |=> s_ff.cmpCnt == 3'h0;
  endproperty
  a_single_cnt: assert property (p_single_cnt) else $error("single count not zero"); // RULE_09

  property p_store_stall;
    @(posedge clk) disable iff (!rst_n)
    (s_ff.fsm == IFBX_IDLE && instr.kind == IFBX_K_STORE_SINGLE && storeHaz) |-> !ctl.fileStoreReq;
  endproperty
  a_store_stall: assert property (p_store_stall) else $error("store over pending octet"); // RULE_11

  property p_store_ack;
    @(posedge clk) disable iff (!rst_n)
    (ctl.fileStoreReq && s_ff.fsm == IFBX_IDLE && instr.kind == IFBX_K_STORE_SINGLE)
      |-> (ctl.passAck == writeAccept);
  endproperty
  a_store_ack: assert property (p_store_ack) else $error("store ack without accept"); // RULE_13

  property p_settle;
    @(posedge clk) disable iff (!rst_n)
    (s_ff.enable && s_ff.fsm == IFBX_IDLE && isBranch && s_ff.hold && !s_ff.branchDone)
      |-> !ctl.decideGo ##1 (s_ff.branchDone && s_ff.hold);
  endproperty
  a_settle: assert property (p_settle) else $error("settle pass wrong"); // RULE_19

  property p_decide;
    @(posedge clk) disable iff (!rst_n)
    ctl.decideGo |-> (s_ff.hold && s_ff.branchDone) ##1 (!s_ff.hold && !s_ff.branchDone);
  endproperty
  a_decide: assert property (p_decide) else $error("decide exit wrong"); // RULE_20

  property p_exch_hold;
    @(posedge clk) disable iff (!rst_n)
    (instr.kind == IFBX_K_EXCHANGE && ctl.l3ToL4 && !s_ff.hold) |=> s_ff.hold;
  endproperty
  a_exch_hold: assert property (p_exch_hold) else $error("exchange hold not set"); // RULE_26

  property p_bus_answer;
    @(posedge clk) disable iff (!rst_n)
    (busReq && !s_ff.busAck) |=> !avs_waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus not answered");

  c_mult_done: cover property (@(posedge clk) disable iff (!rst_n)
    (s_ff.fsm == IFBX_OREQ && s_ff.cmpCnt == 3'h0));
  c_branch_decide: cover property (@(posedge clk) disable iff (!rst_n) ctl.decideGo);
  c_exch_short: cover property (@(posedge clk) disable iff (!rst_n) ctl.shortCircuitL4);
  c_store_single: cover property (@(posedge clk) disable iff (!rst_n)
    (ctl.fileStoreReq && ctl.passAck));

endmodule : ifbx_ctrl

`default_nettype wire

// ===== hw/ifbx_pkg.sv
`default_nettype none

package ifbx_pkg;

  // ************************************************************
  // Widths and fixed values
  // ************************************************************
  localparam int ALPHA_W = 24;
  localparam int MOD_W = 4;
  localparam int BUS_AW = 4;
  localparam logic [ALPHA_W-1:0] REGFILE_TOP = 24'h00002F;
  localparam logic [ALPHA_W-1:0] ALPHA_ZERO = 24'h000000;
  localparam logic [ALPHA_W-1:0] ALPHA_STEP = 24'h000008;
  localparam logic [MOD_W-1:0] MOD_ZERO = 4'h0;
  localparam logic [2:0] MULT_PRESET = 3'h5;
  localparam logic [2:0] SINGLE_PRESET = 3'h0;
  localparam logic [2:0] CNT_STEP = 3'h1;

  // ************************************************************
  // Register map, byte addresses
  // ************************************************************
  localparam logic [BUS_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [BUS_AW-1:0] REG_STATUS = 4'h4;
  localparam logic [BUS_AW-1:0] REG_ALPHA = 4'h8;
  localparam int CTRL_EN_BIT = 0;
  localparam logic CTRL_EN_RESET = 1'b1;
  localparam int STAT_FSM_LSB = 0;
  localparam int STAT_HOLD_BIT = 4;
  localparam int STAT_BDONE_BIT = 5;
  localparam int STAT_TAKEN_BIT = 6;
  localparam int STAT_REQ_LSB = 8;
  localparam int STAT_CMP_LSB = 12;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [3:0] {
    IFBX_K_NONE, IFBX_K_LOAD_MULT, IFBX_K_STORE_MULT, IFBX_K_LOAD_SINGLE,
    IFBX_K_STORE_SINGLE, IFBX_K_STORE_ZERO, IFBX_K_BR_LE, IFBX_K_BR_GT,
    IFBX_K_EXCHANGE, IFBX_K_OTHER
  } ifbx_kind_e;

  typedef enum logic [1:0] {IFBX_IDLE, IFBX_OWAIT, IFBX_OREQ} ifbx_fsm_e;

  typedef struct packed {
    ifbx_kind_e kind;
    logic [ALPHA_W-1:0] alpha;
    logic [MOD_W-1:0] modifier;
    logic regInhibit;
    logic doubleword;
    logic [31:0] testCount;
    logic [31:0] testIndex;
    logic [31:0] testCompare;
  } ifbx_instr_s;

  typedef struct packed {
    logic pipeBusy;
    logic forcedWriteBusy;
    logic zFull;
    logic alphaRegHaz;
    logic resultOctetHaz;
    logic resultRegHaz;
    logic testRegHaz;
    logic alphaMemHaz;
    logic resultMemHaz;
    logic shortCircuitOk;
  } ifbx_haz_s;

  typedef struct packed {
    logic xActive;
    logic xFull;
    logic [ALPHA_W-1:0] xAddr;
    logic yActive;
    logic yFull;
    logic [ALPHA_W-1:0] yAddr;
  } ifbx_buf_s;

  typedef struct packed {
    logic ldInvalidate;
    logic fileLoadReq;
    logic fileStoreReq;
    logic forcedWrite;
    logic fileToFile;
    logic storeZero;
    logic clearXActive;
    logic clearYActive;
    logic seqRegToPipe;
    logic seqMemToPipe;
    logic l3ToL4;
    logic shortCircuitL4;
    logic clearExecInhibit;
    logic passAck;
    logic decideGo;
  } ifbx_out_s;

  typedef struct packed {
    ifbx_fsm_e fsm;
    logic hold;
    logic branchDone;
    logic branchTaken;
    logic alphaInc;
    logic storeOp;
    logic [2:0] reqCnt;
    logic [2:0] cmpCnt;
    logic [ALPHA_W-1:0] alpha;
    logic [31:0] cntOp;
    logic [63:0] pairOp;
    logic enable;
    logic busAck;
    logic [31:0] rdData;
  } ifbx_state_s;

endpackage : ifbx_pkg

`default_nettype wire

// ===== tb/ifbx_cmr_model.sv
`default_nettype none

module ifbx_cmr_model (
  input wire logic clk, // control clock
  input wire logic rst_n, // async reset
  input wire logic loadReq, // file load request
  input wire logic storeReq, // file store request
  input wire logic [3:0] delay, // cycles before accept
  output logic readAccept, // read taken
  output logic writeAccept // write taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waitCnt;
  assign readAccept = loadReq && (waitCnt >= delay);
  // an empty bus stands ready for a write even without a store request.
  assign writeAccept = !loadReq && (!storeReq || (waitCnt >= delay));
  // Outstanding reads keep a real requester busy, so the wait restarts after each accept.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitCnt <= 4'h0;
    end else if ((loadReq || storeReq) && !(readAccept || writeAccept)) begin
      waitCnt <= waitCnt + 4'h1;
    end else begin
      waitCnt <= 4'h0;
    end
  end
endmodule : ifbx_cmr_model

`default_nettype wire

// ===== tb/ifbx_ctrl_tb_top.sv
`default_nettype none

module ifbx_ctrl_tb_top;
  import ifbx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LDI = 14;
  localparam int FTF = 10;
  localparam int STZ = 9;
  localparam int FSR = 12;
  localparam int CXA = 8;
  localparam int SRP = 6;
  localparam int SMP = 5;
  localparam int L34 = 4;
  localparam int SCL = 3;
  localparam int CEI = 2;
  localparam int ACK = 1;
  localparam int DGO = 0;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic waitReq;
  ifbx_instr_s ins = '0;
  ifbx_haz_s hz = '0;
  ifbx_buf_s bf = '0;
  logic rAcc;
  logic wAcc;
  ifbx_out_s ctl;
  logic [23:0] alphaAddr;
  logic [31:0] cntOp;
  logic [63:0] pairOp;
  logic taken;
  logic [3:0] delay = 4'h0;
  logic [23:0] a0 = 24'h000100;
  int cnt [15];
  int nAcc = 0;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;
  int seed = 57539;

  ifbx_ctrl uut (.clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rdat),
    .avs_waitrequest(waitReq), .instr(ins), .haz(hz), .bufs(bf), .readAccept(rAcc),
    .writeAccept(wAcc), .ctl(ctl), .alphaAddr(alphaAddr), .level4CountOperand(cntOp),
    .level4PairOperand(pairOp), .branchTaken(taken));
  ifbx_cmr_model cmr (.clk(clk), .rst_n(rst_n), .loadReq(ctl.fileLoadReq),
    .storeReq(ctl.fileStoreReq), .delay(delay), .readAccept(rAcc), .writeAccept(wAcc));

  always #2 clk = ~clk;

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (e !== g) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // Pulses are combinational, so they are counted mid-cycle once settled.
  always @(negedge clk) begin
    if (ctl.fileLoadReq && rAcc && nAcc == 1) begin
      chk("alpha step", {40'h0, a0 + ALPHA_STEP}, {40'h0, alphaAddr});
    end
    if (ctl.fileLoadReq && rAcc) nAcc++;
    for (int i = 0; i < 15; i++) cnt[i] += int'(ctl[i]);
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      test_done();
    end
  end

  // Waitrequest and read data are taken at the rising edge; one idle edge parts two requests.
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    do @(posedge clk); while (waitReq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic clr();
    for (int i = 0; i < 15; i++) cnt[i] = 0;
  endtask : clr

  task automatic run();
    clr();
    while (cnt[ACK] + cnt[DGO] == 0) @(posedge clk);
    ins.kind <= IFBX_K_NONE;
    @(posedge clk);
  endtask : run

  task automatic stall(input string nm);
    int s;
    s = 0;
    clr();
    repeat (4) @(posedge clk);
    for (int i = 0; i < 15; i++) s += cnt[i];
    chk(nm, 64'h0, 64'(s));
  endtask : stall

  initial begin
    logic [31:0] q;
    logic [33:0] s;
    int n0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, REG_CTRL, 32'h0, q);
    chk("ctrl reset", 64'h1, {32'h0, q});
    bus(1'b1, REG_CTRL, 32'h0, q);
    bus(1'b0, REG_CTRL, 32'h0, q);
    chk("ctrl write", 64'h0, {32'h0, q});
    ins.kind <= IFBX_K_LOAD_MULT;
    stall("disabled");
    ins.kind <= IFBX_K_NONE;
    bus(1'b1, REG_CTRL, 32'h1, q);
    bus(1'b0, 4'hC, 32'h0, q);
    chk("unmapped read", 64'h0, {32'h0, q});
    delay <= 4'($random(seed) & 32'h3);
    ins.alpha <= a0;
    @(posedge clk);
    ins.kind <= IFBX_K_LOAD_MULT;
    run();
    chk("accepted loads", 64'h6, 64'(nAcc));
    chk("load invalidate", 64'h1, 64'(cnt[LDI] > 0));
    bf.xActive <= 1'b1;
    bf.xAddr <= 24'h000200;
    ins.alpha <= 24'h000200;
    ins.kind <= IFBX_K_STORE_SINGLE;
    stall("store hazard");
    bf.xFull <= 1'b1;
    delay <= 4'h3;
    run();
    chk("x activity clear", 64'h1, 64'(cnt[CXA] > 0));
    chk("store retries", 64'h4, 64'(cnt[FSR]));
    bf <= '0;
    ins.alpha <= REGFILE_TOP;
    hz.alphaRegHaz <= 1'b1;
    ins.kind <= IFBX_K_LOAD_SINGLE;
    stall("octet hazard");
    hz.alphaRegHaz <= 1'b0;
    run();
    chk("file to file", 64'h1, 64'(cnt[FTF]));
    chk("flags cleared", 64'h1, 64'(cnt[CEI]));
    ins.kind <= IFBX_K_STORE_ZERO;
    run();
    chk("store zero", 64'h1, 64'(cnt[STZ]));
    ins.alpha <= 24'h000300;
    ins.kind <= IFBX_K_LOAD_SINGLE;
    n0 = nAcc;
    run();
    chk("single load", 64'h1, 64'(nAcc - n0));
    chk("single invalidate", 64'h1, 64'(cnt[LDI] > 0));
    for (int k = 0; k < 2; k++) begin
      ins.kind <= (k == 0) ? IFBX_K_BR_LE : IFBX_K_BR_GT;
      ins.testCount <= $random(seed);
      ins.testIndex <= $random(seed);
      ins.testCompare <= $random(seed);
      hz.testRegHaz <= 1'b1;
      stall("branch hazard");
      hz.testRegHaz <= 1'b0;
      run();
      s = {2'b0, ins.testCount} + {2'b0, ins.testIndex} + {2'b0, ~ins.testCompare};
      chk("count operand", {32'h0, ins.testCount}, {32'h0, cntOp});
      chk("pair operand", {ins.testIndex, ins.testCompare}, pairOp);
      chk("branch taken", 64'(|s[33:32]), {63'h0, taken});
      chk("branch start", 64'h1, 64'(cnt[SRP]));
      chk("branch transfer", 64'h1, 64'(cnt[L34]));
      chk("branch decide", 64'h1, 64'(cnt[DGO]));
    end
    ins.alpha <= 24'h000400;
    ins.kind <= IFBX_K_EXCHANGE;
    hz.resultRegHaz <= 1'b1;
    stall("exchange hazard");
    hz.resultRegHaz <= 1'b0;
    run();
    chk("exchange memory", 64'h1, 64'(cnt[SMP]));
    chk("exchange passes", 64'h2, 64'(cnt[L34]));
    chk("exchange ack", 64'h1, 64'(cnt[ACK]));
    hz.alphaRegHaz <= 1'b1;
    hz.shortCircuitOk <= 1'b1;
    ins.alpha <= 24'h000010;
    ins.kind <= IFBX_K_EXCHANGE;
    run();
    chk("short circuit", 64'h1, 64'(cnt[SCL]));
    test_done();
  end
endmodule : ifbx_ctrl_tb_top

`default_nettype wire
